// File: design/gis_consts.svh
// Summary of operation
// - Upper mode bits pick adapter off, E3 or STS1 input.
// - Select 00 input, 10 low, 11 high.
// - Select 01 drives port A/B status.
// - Pin 8 is update input in mode 01.
// - Pin 6 is error-insert input when selected.
// - Pin 4 is reference input when selected.
// - Pin 2 drives reference output when selected.
// - Port summary bit mirrors port interrupt status.
// - Enabled port summary pulls interrupt low.
// - Global summary is any enabled latched bit.
// - Enabled global summary pulls interrupt low.
// - Lock lost reads one when any loop unlocked.
// - Update complete is AND of request and enabled ports.
// - Reference activity latched, monitored when selected.
// - Adapter reference activity latched on first pin.
// - Interrupt idle is high-Z or driven high.
// - Latched bits clear on write or read.
// - Update-complete and lock-lost latched bits set on live rising edge.
// - One-second latched bit set every second.
`ifndef GIS_CONSTS_SVH
`define GIS_CONSTS_SVH

// ****************************************************************
// Register offsets on the register port.
// ****************************************************************
`define GIS_ADDR_W 11
`define GIS_OFF_GIOC 11'h00A
`define GIS_OFF_ISR 11'h010
`define GIS_OFF_ISRIE 11'h012
`define GIS_OFF_SR 11'h014
`define GIS_OFF_SRL 11'h016

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define GIS_ISR_PORT_LSB 4
`define GIS_ISR_GSR_BIT 0
`define GIS_SRL_GLOBAL_UPDATE_COMPLETE_BIT 0
`define GIS_SRL_LOL_BIT 1
`define GIS_SRL_ONES_BIT 2
`define GIS_SRL_CLAD_BIT 3
`define GIS_SRL_REF_BIT 4
`define GIS_GIOC_RST 16'h0000
`define GIS_SRL_ALL 5'h1F
`define GIS_PIN_FN_INPUT 2'h0
`define GIS_PIN_FN_STATUS 2'h1
`define GIS_PIN_FN_LOW 2'h2
`define GIS_PIN_FN_HIGH 2'h3
`define GIS_CLAD_OFF 2'h0
`define GIS_CLAD_IN_E3 2'h2
`define GIS_CLAD_IN_STS1 2'h3
`define GIS_FREQ_DS3 2'h0
`define GIS_FREQ_E3 2'h1
`define GIS_FREQ_STS1 2'h2
`define GIS_OUT_FIRST 2'h1
`define GIS_OUT_SECOND 2'h2
`define GIS_OUT_BOTH 2'h3

// ****************************************************************
// Timing.
// ****************************************************************
`define GIS_CLK_PERIOD_NS 100
`define GIS_ONE_SEC_NS 1000000000
`define GIS_ACT_WINDOW 256

`endif

// File: design/gis_pkg.sv
`include "gis_consts.svh"

package gis_pkg;

  // Function of one general-purpose pin.
  typedef enum logic [1:0] {
    GIS_FN_INPUT = `GIS_PIN_FN_INPUT,
    GIS_FN_STATUS = `GIS_PIN_FN_STATUS,
    GIS_FN_LOW = `GIS_PIN_FN_LOW,
    GIS_FN_HIGH = `GIS_PIN_FN_HIGH
  } gis_pin_fn_t;

  // Global update mode; both upper codes mean one-second update.
  typedef enum logic [1:0] {
    GIS_UPD_SW = 2'h0,
    GIS_UPD_PIN = 2'h1,
    GIS_UPD_SEC = 2'h2,
    GIS_UPD_SEC_ALT = 2'h3
  } gis_upd_mode_t;

endpackage

// File: design/gis_sync.sv
module gis_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level
);
  import gis_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } gis_sync_st_t;

  gis_sync_st_t st;
  gis_sync_st_t next_st;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 ^ st.s3));
  end

  // The first stage is read only by the second stage.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
endmodule

// File: design/gis_top.sv
`include "gis_consts.svh"

module gis_top #(
  parameter int ONE_SEC_CYCLES = `GIS_ONE_SEC_NS / `GIS_CLK_PERIOD_NS,
  parameter int ACT_WINDOW = `GIS_ACT_WINDOW
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`GIS_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] clock_adapter_pin_mode,
  input wire gis_pkg::gis_upd_mode_t global_update_mode,
  input wire logic error_insert_source_select,
  input wire logic reference_input_select,
  input wire logic reference_output_select,
  input wire logic irq_pin_idle_mode,
  input wire logic latched_clear_on_read_enable,
  input wire logic global_update_request,
  input wire logic [3:0] port_global_update_enable,
  input wire logic [3:0] port_update_complete,
  input wire logic [3:0] port_irq_any,
  input wire logic [3:0] port_status_source_a,
  input wire logic [3:0] port_status_source_b,
  input wire logic [2:0] status_irq_enable,
  input wire logic [2:0] pll_locked,
  input wire logic [2:0] derived_clk,
  input wire logic reference_out_sig,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe_n,
  input wire logic clock_pin_first_in,
  output logic [2:0] clock_pin_out,
  output logic [2:0] clock_pin_oe_n,
  output logic irq_n_out,
  output logic irq_n_oe_n,
  output logic update_request_ext,
  output logic error_insert_ext,
  output logic reference_in,
  output logic global_update_complete
);
  import gis_pkg::*;

  localparam int WIN_W = $clog2(ACT_WINDOW);

  typedef struct packed {
    logic [15:0] gioc;
    logic [3:0] pie;
    logic gie;
    logic [4:0] srl;
    logic prev_lol;
    logic prev_done;
    logic [31:0] sec_cnt;
    logic [WIN_W-1:0] win_cnt;
    logic [1:0] seen;
    logic [1:0] prev_act;
    logic [15:0] rdata;
    logic [7:0] gout;
    logic [7:0] goe_n;
    logic [2:0] cout;
    logic [2:0] coe_n;
    logic irq_n;
    logic irq_oe_n;
    logic upd_ext;
    logic eis_ext;
    logic ref_in;
    logic done;
  } gis_top_st_t;

  localparam gis_top_st_t ST_RST = '{
    gioc: `GIS_GIOC_RST,
    goe_n: 8'hFF,
    coe_n: 3'h7,
    irq_n: 1'b1,
    irq_oe_n: 1'b1,
    default: '0
  };

  gis_top_st_t st;
  gis_top_st_t next_st;
  logic [8:0] sync_lvl;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  // Pins come from outside the clock domain, so all pass three stages.
  gis_sync #(
    .W(9)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({clock_pin_first_in, gpio_in}),
    .level(sync_lvl)
  );

  // ****************************************************************
  // Live status and summaries.
  // ****************************************************************
  logic lol;
  logic done;
  logic global_summary_bit;
  logic irq_act;
  logic sec_tick;
  logic win_end;
  logic [1:0] act_src;
  logic [1:0] act_tr;
  logic [4:0] srl_set;
  logic [4:0] srl_clr;
  logic wr_srl;
  logic rd_srl;

  // Live flags and the interrupt condition, from current inputs and state.
  assign lol = ~&pll_locked;
  assign done = global_update_request
    & (&(port_update_complete | ~port_global_update_enable));
  assign global_summary_bit = |(st.srl[2:0] & status_irq_enable);
  assign irq_act = (|(port_irq_any & st.pie))
    | (global_summary_bit & st.gie);
  assign sec_tick = st.sec_cnt == 32'(ONE_SEC_CYCLES - 1);
  assign win_end = st.win_cnt == WIN_W'(ACT_WINDOW - 1);

  // Reference on pin 4 is watched only while it is selected as input.
  assign act_src[0] = sync_lvl[3] & reference_input_select;
  assign act_src[1] = sync_lvl[8];
  assign act_tr = act_src ^ st.prev_act;

  // Latched set sources; a set in the clearing cycle wins.
  assign srl_set[`GIS_SRL_GLOBAL_UPDATE_COMPLETE_BIT] = done & ~st.prev_done;
  assign srl_set[`GIS_SRL_LOL_BIT] = lol & ~st.prev_lol;
  assign srl_set[`GIS_SRL_ONES_BIT] = sec_tick;
  assign srl_set[`GIS_SRL_CLAD_BIT] = win_end & (st.seen[1] | act_tr[1]);
  assign srl_set[`GIS_SRL_REF_BIT] = win_end & (st.seen[0] | act_tr[0]);

  // Clear by write of ones while clear-on-read is off, or by any read of the latched register when clear-on-read is set.
  assign wr_srl = reg_wr & (reg_addr == `GIS_OFF_SRL);
  assign rd_srl = reg_rd & (reg_addr == `GIS_OFF_SRL);
  assign srl_clr = (wr_srl & ~latched_clear_on_read_enable)
    ? reg_wdata[4:0]
    : ((rd_srl & latched_clear_on_read_enable) ? `GIS_SRL_ALL : 5'h00);

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // All state is computed here and registered in one process below.
  always_comb begin
    logic [1:0] sel;
    logic sig;
    logic [1:0] hi;
    logic [1:0] lo;
    logic fx;
    logic fy;
    sel = 2'h0;
    sig = 1'b0;
    hi = clock_adapter_pin_mode[3:2];
    lo = clock_adapter_pin_mode[1:0];
    fx = 1'b0;
    fy = 1'b0;
    next_st = st;

    // Register writes.
    if (reg_wr && reg_addr == `GIS_OFF_GIOC) begin
      next_st.gioc = reg_wdata;
    end
    if (reg_wr && reg_addr == `GIS_OFF_ISRIE) begin
      next_st.pie = reg_wdata[7:4];
      next_st.gie = reg_wdata[0];
    end

    // Register reads are answered one cycle after the strobe.
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `GIS_OFF_GIOC: next_st.rdata = st.gioc;
        `GIS_OFF_ISR: begin
          next_st.rdata[`GIS_ISR_PORT_LSB +: 4] = port_irq_any;
          next_st.rdata[`GIS_ISR_GSR_BIT] = global_summary_bit;
        end
        `GIS_OFF_ISRIE: begin
          next_st.rdata[7:4] = st.pie;
          next_st.rdata[0] = st.gie;
        end
        `GIS_OFF_SR: next_st.rdata[1:0] = {lol, done};
        `GIS_OFF_SRL: next_st.rdata[4:0] = st.srl;
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // Latched status, edge history and timers.
    next_st.srl = (st.srl & ~srl_clr) | srl_set;
    next_st.prev_lol = lol;
    next_st.prev_done = done;
    next_st.done = done;
    next_st.sec_cnt = sec_tick ? 32'h0 : st.sec_cnt + 32'h1;
    next_st.win_cnt = win_end ? '0 : st.win_cnt + WIN_W'(1);
    next_st.seen = win_end ? 2'h0 : (st.seen | act_tr);
    next_st.prev_act = act_src;

    // General pins; odd pins carry status A, even pins status B.
    for (int i = 0; i < 8; i++) begin
      sel = st.gioc[2*i +: 2];
      sig = (i % 2 == 0) ? port_status_source_a[i/2]
        : port_status_source_b[i/2];
      next_st.gout[i] = (sel == GIS_FN_HIGH)
        | ((sel == GIS_FN_STATUS) & sig);
      next_st.goe_n[i] = (sel == GIS_FN_INPUT);
    end
    // Pins that other global functions borrow.
    if (global_update_mode == GIS_UPD_PIN) begin
      next_st.goe_n[7] = 1'b1;
      next_st.gout[7] = 1'b0;
    end
    if (error_insert_source_select) begin
      next_st.goe_n[5] = 1'b1;
      next_st.gout[5] = 1'b0;
    end
    if (reference_input_select) begin
      next_st.goe_n[3] = 1'b1;
      next_st.gout[3] = 1'b0;
    end
    if (reference_output_select) begin
      next_st.goe_n[1] = 1'b0;
      next_st.gout[1] = reference_out_sig;
    end
    // Borrowed inputs read low while their function is off.
    next_st.upd_ext = sync_lvl[7] & (global_update_mode == GIS_UPD_PIN);
    next_st.eis_ext = sync_lvl[5] & error_insert_source_select;
    next_st.ref_in = act_src[0];

    // Clock pins: the first is always an input, the others may drive.
    fx = derived_clk[(hi == `GIS_CLAD_IN_E3) ? `GIS_FREQ_DS3
      : `GIS_FREQ_E3];
    fy = derived_clk[(hi == `GIS_CLAD_IN_STS1) ? `GIS_FREQ_DS3
      : `GIS_FREQ_STS1];
    next_st.coe_n = 3'h7;
    next_st.cout = 3'h0;
    if (hi != `GIS_CLAD_OFF) begin
      next_st.coe_n = 3'h1;
      next_st.cout[1] = (lo == `GIS_OUT_FIRST) ? fx
        : ((lo == `GIS_OUT_BOTH) ? fy : 1'b0);
      next_st.cout[2] = (lo == `GIS_OUT_SECOND) ? fy
        : ((lo == `GIS_OUT_BOTH) ? fx : 1'b0);
    end

    // Interrupt pin; in high-Z idle mode the board pull-up holds it.
    next_st.irq_n = ~irq_act;
    next_st.irq_oe_n = ~(irq_act | irq_pin_idle_mode);
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Single register stage so every output comes from a flip-flop.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are straight register bits.
  assign reg_rdata = st.rdata;
  assign gpio_out = st.gout;
  assign gpio_oe_n = st.goe_n;
  assign clock_pin_out = st.cout;
  assign clock_pin_oe_n = st.coe_n;
  assign irq_n_out = st.irq_n;
  assign irq_n_oe_n = st.irq_oe_n;
  assign update_request_ext = st.upd_ext;
  assign error_insert_ext = st.eis_ext;
  assign reference_in = st.ref_in;
  assign global_update_complete = st.done;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_pin1_low;
    st.gioc[1:0] == GIS_FN_LOW;
  endsequence
  sequence s_wclr_ones;
    wr_srl && !latched_clear_on_read_enable && reg_wdata[2] && !sec_tick;
  endsequence
  sequence s_lol_rise;
    !lol ##1 lol;
  endsequence

  AST_PIN1_LOW: assert property (
    s_pin1_low |=> !gpio_oe_n[0] && !gpio_out[0])
    else $error("pin 1 not driven low");
  AST_PIN1_STAT: assert property (
    st.gioc[1:0] == GIS_FN_STATUS |=>
      gpio_out[0] == $past(port_status_source_a[0]))
    else $error("pin 1 status mismatch");
  AST_PIN8_UPD: assert property (
    global_update_mode == GIS_UPD_PIN |=> gpio_oe_n[7])
    else $error("pin 8 driven in pin update mode");
  AST_PIN6_EIS: assert property (
    error_insert_source_select |=> gpio_oe_n[5])
    else $error("pin 6 driven while error input");
  AST_PIN2_REF: assert property (
    reference_output_select |=>
      !gpio_oe_n[1] && gpio_out[1] == $past(reference_out_sig))
    else $error("pin 2 not driving reference");
  AST_IRQ_ACT: assert property (
    irq_act |=> !irq_n_out && !irq_n_oe_n)
    else $error("interrupt pin not low");
  AST_IRQ_IDLE: assert property (
    !irq_act && !irq_pin_idle_mode |=> irq_n_oe_n && irq_n_out)
    else $error("interrupt pin driven while idle");
  AST_LOL_LATCH: assert property (
    s_lol_rise |=> st.srl[`GIS_SRL_LOL_BIT])
    else $error("lock loss not latched");
  AST_WR_CLEAR: assert property (
    s_wclr_ones |=> !st.srl[`GIS_SRL_ONES_BIT])
    else $error("write did not clear latched bit");
  AST_SEC_TICK: assert property (
    sec_tick |=> st.srl[`GIS_SRL_ONES_BIT] && st.sec_cnt == 32'h0)
    else $error("second tick not latched");
  AST_CLK_MODE: assert property (
    clock_adapter_pin_mode[3:2] == `GIS_CLAD_OFF |=> clock_pin_oe_n == 3'h7)
    else $error("clock pin driven in input mode");
endmodule

// File: verification/gis_host.sv
module gis_host (
  input wire logic ref_clk,
  input wire logic [15:0] reg_rdata,
  input wire logic upd_done,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_n,
  output logic [10:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  output logic upd_req,
  output logic irq_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line has a pull-up, so an undriven pin reads high.
  assign irq_level = irq_n_oe_n ? 1'b1 : irq_n_out;

  // Idle bus before the first access.
  initial begin
    reg_addr = 11'h7FF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'hFFFF;
    upd_req = 1'b0;
  end

  // One idle edge first, so a strobe dropped by the previous call is
  // never raised again in the same time step. The bus is inverted
  // afterwards so stale values never look valid.
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read data is taken at the edge that accepts the strobe.
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  // Request is held until completion shows or 40 cycles pass, then dropped.
  task automatic upd(output logic ok);
    ok = 1'b0;
    upd_req = 1'b1;
    for (int n = 0; n < 40 && ok !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
      ok = upd_done;
    end
    upd_req = 1'b0;
  endtask
endmodule

// File: verification/global_io_interrupt_status_test.sv
`include "gis_consts.svh"

module global_io_interrupt_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  import gis_pkg::*;

  // ****
  // Bench signals and instances.
  // ****
  logic ref_clk, rst, reg_wr, reg_rd, upd_req, irq_level, ok, cpa;
  logic [10:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0] cm, pgue, puc, pia, ssa, ssb;
  gis_upd_mode_t gum;
  logic eis, ris, ros, idle, cor, rsig, irq_out, irq_oe_n;
  logic [2:0] sie, pll, dclk, c_oe_n, c_out;
  logic [7:0] gin, gout, goe_n, eoe_n, eout;
  logic upd_ext, err_ext, ref_in, gdone;
  int err_count, num_checks, cycles;

  gis_top #(.ONE_SEC_CYCLES(50), .ACT_WINDOW(8)) gis_top_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .clock_adapter_pin_mode(cm),
    .global_update_mode(gum), .error_insert_source_select(eis),
    .reference_input_select(ris), .reference_output_select(ros),
    .irq_pin_idle_mode(idle), .latched_clear_on_read_enable(cor),
    .global_update_request(upd_req), .port_global_update_enable(pgue),
    .port_update_complete(puc), .port_irq_any(pia),
    .port_status_source_a(ssa), .port_status_source_b(ssb),
    .status_irq_enable(sie), .pll_locked(pll), .derived_clk(dclk),
    .reference_out_sig(rsig), .gpio_in(gin), .gpio_out(gout),
    .gpio_oe_n(goe_n), .clock_pin_first_in(cpa),
    .clock_pin_out(c_out), .clock_pin_oe_n(c_oe_n),
    .irq_n_out(irq_out), .irq_n_oe_n(irq_oe_n),
    .update_request_ext(upd_ext), .error_insert_ext(err_ext),
    .reference_in(ref_in), .global_update_complete(gdone)
  );

  gis_host gis_host_i (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .upd_done(gdone),
    .irq_n_out(irq_out), .irq_n_oe_n(irq_oe_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .upd_req(upd_req), .irq_level(irq_level)
  );

  // Clock at 10 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard; the whole run needs under 2000 cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic rc(input logic [10:0] a, input logic [15:0] m, e,
                    input string nm);
    logic [15:0] v;
    gis_host_i.rd(a, v);
    chk(nm, v & m, e);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Expected pin drive and level from selects and overrides.
  function automatic void pin_model(input logic [15:0] g);
    logic [1:0] f;
    for (int i = 0; i < 8; i++) begin
      f = g[2*i+:2];
      eoe_n[i] = f == GIS_FN_INPUT;
      eout[i] = f == GIS_FN_HIGH ||
        (f == GIS_FN_STATUS && (i[0] ? ssb[i/2] : ssa[i/2]));
    end
    if (gum == GIS_UPD_PIN) eoe_n[7] = 1'b1;
    if (eis) eoe_n[5] = 1'b1;
    if (ris) eoe_n[3] = 1'b1;
    if (ros) eoe_n[1] = 1'b0;
    if (ros) eout[1] = rsig;
    eout = eout & ~eoe_n;
  endfunction

  // Returns drive enables over levels for the three clock pins.
  function automatic logic [5:0] clk_model(input logic [3:0] m);
    int o1, o2;
    logic [2:0] o;
    o1 = m[3:2] == 2'h2 ? 0 : 1;
    o2 = m[3:2] == 2'h3 ? 0 : 2;
    o[0] = 1'b0;
    o[1] = m[0] && dclk[m[1] ? o2 : o1];
    o[2] = m[1] && dclk[m[0] ? o1 : o2];
    return m[3:2] == 2'h0 ? 6'h38 : {3'h1, o};
  endfunction

  // ****
  // Test sequence.
  // ****
  initial begin
    rst = 1'b1;
    {cm, pgue, puc, pia, ssa, ssb, sie, dclk, gin} = '0;
    {eis, ris, ros, idle, cor, rsig, cpa} = '0;
    gum = GIS_UPD_SW;
    pll = 3'h7;
    void'($urandom(99));
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk("oe_n", 16'(goe_n), 16'h00FF);
    rc(`GIS_OFF_GIOC, 16'hFFFF, 16'h0, "gioc");
    rc(`GIS_OFF_ISRIE, 16'hFFFF, 16'h0, "isrie");
    gis_host_i.wr(11'h000, 16'h1234);
    gis_host_i.wr(`GIS_OFF_ISR, 16'hFFFF);
    rc(11'h000, 16'hFFFF, 16'h0, "unmapped");
    rc(`GIS_OFF_ISR, 16'hFFFF, 16'h0, "isr");
    rc(`GIS_OFF_SRL, 16'hFFFF, 16'h0, "srl");
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      d = k < 4 ? {8{2'(k)}} : 16'($urandom);
      {eis, ris, ros} = k == 6 ? 3'h7 : k > 6 ? 3'($urandom) : 3'h0;
      gum = gis_upd_mode_t'(k == 6 ? 2'h1 : k > 6 ? 2'($urandom) : 2'h0);
      {ssa, ssb, gin, rsig} = 17'($urandom);
      gis_host_i.wr(`GIS_OFF_GIOC, d);
      cyc(6);
      pin_model(d);
      chk("oe_n", 16'(goe_n), 16'(eoe_n));
      chk("out", 16'(gout & ~eoe_n), 16'(eout));
      chk("ext", {13'h0, upd_ext, err_ext, ref_in}, {13'h0,
        gum == GIS_UPD_PIN && gin[7], eis && gin[5], ris && gin[3]}
      );
      rc(`GIS_OFF_GIOC, 16'hFFFF, d, "gioc");
    end
    $display("test pins done");
    for (int m = 0; m < 16; m++) begin
      cm = 4'(m);
      dclk = 3'($urandom);
      cyc(4);
      chk("clk", {10'h0, c_oe_n, c_out & ~c_oe_n},
        {10'h0, clk_model(cm)});
    end
    $display("test clock pins done");
    gis_host_i.wr(`GIS_OFF_SRL, 16'h001F);
    for (int k = 0; k < 8; k++) begin
      {pia, d} = 20'($urandom);
      idle = k[0];
      gis_host_i.wr(`GIS_OFF_ISRIE, d);
      cyc(3);
      rc(`GIS_OFF_ISR, 16'h00F0, {8'h0, pia, 4'h0}, "isr");
      rc(`GIS_OFF_ISRIE, 16'hFFFF, d & 16'h00F1, "isrie");
      chk("irq_oe_n", 16'(irq_oe_n),
        16'(!(|(pia & d[7:4])) && !idle));
      chk("irq", 16'(irq_level), 16'(!(|(pia & d[7:4]))));
    end
    $display("test port interrupts done");
    pia = 4'h0;
    sie = 3'h2;
    gis_host_i.wr(`GIS_OFF_ISRIE, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      cor = k[0];
      pll = 3'h5;
      cyc(6);
      rc(`GIS_OFF_SR, 16'h0002, 16'h0002, "lol");
      rc(`GIS_OFF_ISR, 16'h0001, 16'h0001, "gsum");
      chk("irq", 16'(irq_level), 16'h0);
      pll = 3'h7;
      cyc(6);
      rc(`GIS_OFF_SR, 16'h0002, 16'h0, "lol");
      rc(`GIS_OFF_SRL, 16'h0002, 16'h0002, "lol_l");
      if (!cor) gis_host_i.wr(`GIS_OFF_SRL, 16'h0002);
      rc(`GIS_OFF_SRL, 16'h0002, 16'h0, "lol_l");
      cyc(2);
      chk("irq", 16'(irq_level), 16'h1);
    end
    $display("test lock loss done");
    cor = 1'b0;
    pgue = 4'hA;
    gis_host_i.wr(`GIS_OFF_SRL, 16'h001F);
    fork
      gis_host_i.upd(ok);
      begin
        cyc(4);
        chk("upd", 16'(gdone), 16'h0);
        puc = 4'h2;
        cyc(4);
        chk("upd", 16'(gdone), 16'h0);
        puc = 4'hA;
      end
    join
    chk("upd_ok", 16'(ok), 16'h1);
    cyc(3);
    chk("upd", 16'(gdone), 16'h0);
    rc(`GIS_OFF_SRL, 16'h0001, 16'h0001, "upd_l");
    $display("test update done");
    for (int k = 0; k < 2; k++) begin
      ris = k[0];
      // A select change is itself a transition; let its window close
      // before the clear so it cannot set the bit afterwards.
      cyc(10);
      gis_host_i.wr(`GIS_OFF_SRL, 16'h001F);
      for (int n = 0; n < 30; n++) begin
        cyc(3);
        gin[3] = ~gin[3];
        cpa = ~cpa;
      end
      rc(`GIS_OFF_SRL, 16'h001C, {11'h0, k[0], 4'hC},
        "act");
    end
    $display("test activity done");
    complete_run();
  end
endmodule
